// ### rfcal_cfg.svh
// Purpose: Constants for the power-up and calibration configuration register
// Assumes: Included by bare name from the top, timeout and bench files
// Notes: Overview of operation follows
// Overview of operation
// - Autocal 00 never calibrates alone; 01 calibrates on each idle-to-receive entry
// - Autocal 10 calibrates on every automatic receive-to-idle return
// - Autocal 11 calibrates on every fourth automatic return, skipping three
// - Chip ready low after 1, 16, 64 or 256 ripple expiries past settle
// - Keep-oscillator bit holds the crystal oscillator running during sleep
// - Settled flag and chip ready assert in the same cycle
// - Packet end returns to idle when after-receive select is 00; 11 stays
`ifndef RFCAL_CFG_SVH
`define RFCAL_CFG_SVH

`define RFCAL_ADDR_W 6
`define RFCAL_REG_ADDR 6'h18
`define RFCAL_REG_RESET 8'h04
`define RFCAL_AUTOCAL_HI 5
`define RFCAL_AUTOCAL_LO 4
`define RFCAL_TIMEOUT_HI 3
`define RFCAL_TIMEOUT_LO 2
`define RFCAL_SPARE_BIT 1
`define RFCAL_KEEP_BIT 0
`define RFCAL_USED_MASK 8'h3f
`define RFCAL_RXOFF_IDLE 2'h0
`define RFCAL_RXOFF_STAY 2'h3
`define RFCAL_QUAD_LAST 2'h3
`define RFCAL_RIPPLE_W 6
`define RFCAL_EXP_W 9
`define RFCAL_EXP_SEL0 9'h001
`define RFCAL_EXP_SEL1 9'h010
`define RFCAL_EXP_SEL2 9'h040
`define RFCAL_EXP_SEL3 9'h100

`endif

// ### rfcal_host.sv
// Purpose: Host model driving the configuration register port
// Assumes: Strobes change 1 ns after the rising edge
// Notes: Released data lines show the inverse of the last byte
`timescale 1ns/1ps
module rfcal_host (
    // Clock
    input wire logic i_clk,
    // Register port
    input wire logic [7:0] i_reg_rdata,
    output logic o_reg_wr,
    output logic o_reg_rd,
    output logic [5:0] o_reg_addr,
    output logic [7:0] o_reg_wdata
);
    initial begin
        o_reg_wr = 1'b0;
        o_reg_rd = 1'b0;
        o_reg_addr = 6'h00;
        o_reg_wdata = 8'h00;
    end
    // Timeout 2 suits both oscillator-on and oscillator-off power-down
    function automatic logic [7:0] safe_cfg(input logic keep);
        return {6'h02, 1'b0, keep};
    endfunction : safe_cfg
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        o_reg_addr = a;
        o_reg_wdata = d;
        o_reg_wr = 1'b1;
        @(posedge i_clk);
        #1 o_reg_wr = 1'b0;
        o_reg_wdata = ~d;
        // Idle edge so a following call never retoggles the strobe in one step
        @(posedge i_clk);
        #1;
    endtask : wr
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        o_reg_addr = a;
        o_reg_rd = 1'b1;
        @(posedge i_clk);
        #1 o_reg_rd = 1'b0;
        o_reg_addr = ~a;
        // Registered read data stands for the cycle after the read edge
        d = i_reg_rdata;
        @(posedge i_clk);
        #1;
    endtask : rd
endmodule : rfcal_host

// ### rfcal_pkg.sv
// Purpose: Types shared by the power-up and calibration logic
// Assumes: Nothing imported anywhere; use rfcal_pkg::name
// Notes: Mode codes follow the register field encoding
package rfcal_pkg;
    typedef enum logic [1:0] {
        RFCAL_CAL_NEVER = 2'h0,
        RFCAL_CAL_RX_ENTRY = 2'h1,
        RFCAL_CAL_EACH_RETURN = 2'h2,
        RFCAL_CAL_FOURTH_RETURN = 2'h3
    } rfcal_autocal_t;
    typedef logic [1:0] rfcal_timeout_t;
endpackage : rfcal_pkg

// ### rfcal_tb.sv
// Purpose: Self-checking bench for the power-up and calibration register
// Assumes: Clock enable high except one freeze check; events are single-cycle pulses
// Notes: Calibration expectations come from an integer mod-4 model
`timescale 1ns/1ps
`include "rfcal_cfg.svh"
module tb;
    logic i_clk = 0, i_sys_rst = 1, cal = 0, i2r = 0, rxd = 0, slp = 0, ok = 0, en = 1;
    logic [1:0] ars = 2'h0;
    logic wr, rd, o_en, rdy_n, stl, cal_o, ret_o;
    logic [5:0] addr;
    logic [7:0] wd, rdat, v, wv;
    int err_total = 0, n_compared = 0, cyc = 0, q = 0, seed = 32'h6f12, k, t0 = 0, n = 0;
    always #2.5 i_clk = ~i_clk;
    rfcal_host h (.i_clk(i_clk), .i_reg_rdata(rdat), .o_reg_wr(wr), .o_reg_rd(rd),
        .o_reg_addr(addr), .o_reg_wdata(wd));
    rfcal_top dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_clk_en(en), .i_reg_wr(wr),
        .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wd), .o_reg_rdata(rdat),
        .i_calibrate_strobe(cal), .i_idle_to_rx(i2r), .i_rx_done(rxd),
        .i_after_receive_state_select(ars), .i_sleep(slp), .i_crystal_osc_ok(ok),
        .o_crystal_osc_en(o_en), .o_chip_ready_n(rdy_n), .o_osc_settled_flag(stl),
        .o_synth_cal_start(cal_o), .o_auto_return_idle(ret_o));
    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        n_compared++;
        if (s !== e) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic finish_test();
        $display("Counts: %0d compared, %0d mismatches", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test
    // Pulse one event input and look at the registered answer
    task automatic ev(input int w, input logic ec, input logic er);
        case (w)
            0: cal = 1'b1;
            1: i2r = 1'b1;
            default: rxd = 1'b1;
        endcase
        @(posedge i_clk);
        #1 {cal, i2r, rxd} = 3'h0;
        chk("cal_start", cal_o, ec);
        chk("auto_return", ret_o, er);
        // Idle edge between pulses; each answer lasts one cycle only
        @(posedge i_clk);
        #1 chk("cal_end", cal_o, 1'b0);
        chk("return_end", ret_o, 1'b0);
    endtask : ev
    // Ceiling well above the roughly 30k cycles the tests need
    always @(posedge i_clk) if (++cyc > 40000) begin
        err_total++;
        finish_test();
    end
    initial begin
        repeat (16) @(posedge i_clk);
        #1 i_sys_rst = 1'b0;
        h.rd(6'h18, v);
        chk("reg_reset", v, `RFCAL_REG_RESET);
        h.rd(6'h19, v);
        chk("unmapped", v, 8'h00);
        for (k = 0; k < 4; k++) begin
            wv = 8'($random(seed));
            h.wr(6'h18, wv);
            h.wr(6'h17, ~wv);
            h.rd(6'h18, v);
            chk("readback", v, wv & `RFCAL_USED_MASK);
            chk("rdata_idle", rdat, 8'h00);
        end
        // Frozen clock enable must swallow a write
        en = 1'b0;
        h.wr(6'h18, ~wv);
        en = 1'b1;
        h.rd(6'h18, v);
        chk("frozen_write", v, wv & `RFCAL_USED_MASK);
        $display("Register test done");
        for (k = 0; k < 4; k++) begin
            h.wr(6'h18, {2'h0, k[1:0], 4'h4});
            ev(1, k == 1, 1'b0);
            ev(0, 1'b1, 1'b0);
            repeat (5) begin
                ars = 2'h0;
                ev(2, k == 2 || (k == 3 && q == 3), 1'b1);
                q = (q + 1) % 4;
                ars = 2'h3;
                ev(2, 1'b0, 1'b0);
            end
        end
        $display("Calibration test done");
        for (k = 0; k < 4; k++) begin
            h.wr(6'h18, {4'h0, k[1:0], 2'h0});
            ok = 1'b0;
            repeat (8) @(posedge i_clk);
            #1 ok = 1'b1;
            t0 = cyc;
            // Expiry counts 1, 16, 64, 256 of a 64-cycle ripple period
            n = (k == 0) ? 1 : (16 << (2 * (k - 1)));
            while (rdy_n !== 1'b0 && cyc - t0 < 17000) begin
                @(posedge i_clk);
                #1 chk("settled_vs_ready", stl, !rdy_n);
            end
            chk("timeout_window", cyc - t0 >= 64 * n && cyc - t0 <= 64 * n + 8, 1'b1);
        end
        $display("Timeout test done");
        for (k = 0; k < 2; k++) begin
            h.wr(6'h18, h.safe_cfg(k[0]));
            slp = 1'b1;
            repeat (8) @(posedge i_clk);
            #1 chk("osc_en_sleep", o_en, k[0]);
            chk("ready_sleep", rdy_n, !k[0]);
            slp = 1'b0;
            // Wake with the oscillator stopped needs the full 64 expiries of timeout 2 before ready
            repeat (4110) @(posedge i_clk);
            #1 chk("ready_wake", rdy_n, 1'b0);
        end
        $display("Sleep test done");
        finish_test();
    end
endmodule : tb

// ### rfcal_timeout.sv
// Purpose: Ripple-counter power-on timeout after oscillator settle
// Assumes: i_start is synchronous and high while the oscillator is settled
// Notes: Dropping i_start rearms the whole count
`timescale 1ns/1ps
`include "rfcal_cfg.svh"
module rfcal_timeout #(
    parameter int RIPPLE_W = `RFCAL_RIPPLE_W
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_clk_en,
    // Control
    input wire logic i_start,
    input wire rfcal_pkg::rfcal_timeout_t i_sel,
    // Status
    output logic o_done
);
    generate
        if (RIPPLE_W < 1 || RIPPLE_W > 16) begin : g_bad_width
            $error("rfcal_timeout: ripple width out of range");
        end
    endgenerate

    function automatic logic [`RFCAL_EXP_W-1:0] expiry_target(input logic [1:0] sel);
        case (sel)
            2'h0: expiry_target = `RFCAL_EXP_SEL0;
            2'h1: expiry_target = `RFCAL_EXP_SEL1;
            2'h2: expiry_target = `RFCAL_EXP_SEL2;
            default: expiry_target = `RFCAL_EXP_SEL3;
        endcase
    endfunction : expiry_target

    logic [RIPPLE_W-1:0] ripple_r;
    logic [`RFCAL_EXP_W-1:0] exp_r;
    wire logic tick = &ripple_r;
    wire logic [`RFCAL_EXP_W-1:0] target = expiry_target(i_sel);
    wire logic [`RFCAL_EXP_W-1:0] exp_nxt = exp_r + `RFCAL_EXP_W'(1);
    // Compare with >= so a smaller selection mid-count still finishes
    wire logic hit = i_start && !o_done && tick && (exp_nxt >= target);

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ripple_r <= '0;
            exp_r <= '0;
            o_done <= 1'b0;
        end else if (i_clk_en) begin
            if (!i_start) begin
                ripple_r <= '0;
                exp_r <= '0;
                o_done <= 1'b0;
            end else if (!o_done) begin
                ripple_r <= ripple_r + RIPPLE_W'(1);
                if (tick) begin
                    exp_r <= exp_nxt;
                end
                o_done <= hit;
            end
        end
    end

    a_timeout_count: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        $rose(o_done) |-> ($past(exp_r) + `RFCAL_EXP_W'(1) >= $past(target)) && $past(tick))
        else $error("ready asserted before expiry count reached");
endmodule : rfcal_timeout

// ### rfcal_top.sv
// Purpose: Power-up timeout, oscillator keep and synthesizer autocal control
// Assumes: Register port driven by serial-interface logic on i_clk
// Notes: Outputs all registered; i_clk_en low freezes every flop
`timescale 1ns/1ps
`include "rfcal_cfg.svh"
module rfcal_top (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_clk_en,
    // Register port from serial interface
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [`RFCAL_ADDR_W-1:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    // Radio control state machine events
    input wire logic i_calibrate_strobe,
    input wire logic i_idle_to_rx,
    input wire logic i_rx_done,
    input wire logic [1:0] i_after_receive_state_select,
    input wire logic i_sleep,
    // Oscillator
    input wire logic i_crystal_osc_ok,
    output logic o_crystal_osc_en,
    // Status and commands out
    output logic o_chip_ready_n,
    output logic o_osc_settled_flag,
    output logic o_synth_cal_start,
    output logic o_auto_return_idle
);
    logic [7:0] cfg_r;
    logic osc_meta_r;
    logic osc_sync_r;
    logic [1:0] quad_r;
    logic ready_done;

    wire logic reg_hit = (i_reg_addr == `RFCAL_REG_ADDR);
    wire rfcal_pkg::rfcal_autocal_t synth_autocal_select =
        rfcal_pkg::rfcal_autocal_t'(cfg_r[`RFCAL_AUTOCAL_HI:`RFCAL_AUTOCAL_LO]);
    wire rfcal_pkg::rfcal_timeout_t poweron_timeout_select =
        cfg_r[`RFCAL_TIMEOUT_HI:`RFCAL_TIMEOUT_LO];
    wire logic keep_osc_in_sleep = cfg_r[`RFCAL_KEEP_BIT];

    // Stay-in-receive setting never produces a return
    wire logic auto_return = i_rx_done &&
        (i_after_receive_state_select == `RFCAL_RXOFF_IDLE);
    wire logic quad_wrap = (quad_r == `RFCAL_QUAD_LAST);
    wire logic cal_rx_entry = (synth_autocal_select == rfcal_pkg::RFCAL_CAL_RX_ENTRY)
        && i_idle_to_rx;
    wire logic cal_each = (synth_autocal_select == rfcal_pkg::RFCAL_CAL_EACH_RETURN)
        && auto_return;
    wire logic cal_fourth = (synth_autocal_select == rfcal_pkg::RFCAL_CAL_FOURTH_RETURN)
        && auto_return && quad_wrap;
    // Mode 00 leaves only the host strobe
    wire logic cal_nxt = i_calibrate_strobe || cal_rx_entry || cal_each || cal_fourth;
    wire logic osc_en_nxt = !i_sleep || keep_osc_in_sleep;
    wire logic [7:0] rdata_nxt = (i_reg_rd && reg_hit) ? cfg_r : 8'h00;

    // Oscillator good comes from the analog side, so it is synchronised
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            osc_meta_r <= 1'b0;
            osc_sync_r <= 1'b0;
        end else if (i_clk_en) begin
            osc_meta_r <= i_crystal_osc_ok;
            osc_sync_r <= osc_meta_r;
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cfg_r <= `RFCAL_REG_RESET;
            o_reg_rdata <= 8'h00;
        end else if (i_clk_en) begin
            if (i_reg_wr && reg_hit) begin
                cfg_r <= i_reg_wdata & `RFCAL_USED_MASK;
            end
            o_reg_rdata <= rdata_nxt;
        end
    end

    // Counter runs in every mode so a switch to mode 11 keeps its phase
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            quad_r <= 2'h0;
        end else if (i_clk_en && auto_return) begin
            quad_r <= quad_r + 2'h1;
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_synth_cal_start <= 1'b0;
            o_auto_return_idle <= 1'b0;
            o_crystal_osc_en <= 1'b1;
        end else if (i_clk_en) begin
            o_synth_cal_start <= cal_nxt;
            o_auto_return_idle <= auto_return;
            o_crystal_osc_en <= osc_en_nxt;
        end
    end

    rfcal_timeout #(
        .RIPPLE_W(`RFCAL_RIPPLE_W)
    ) u_timeout (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_clk_en(i_clk_en),
        .i_start(osc_sync_r && o_crystal_osc_en),
        .i_sel(poweron_timeout_select),
        .o_done(ready_done)
    );

    // One flop stage for both keeps them locked together
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_chip_ready_n <= 1'b1;
            o_osc_settled_flag <= 1'b0;
        end else if (i_clk_en) begin
            o_chip_ready_n <= !ready_done;
            o_osc_settled_flag <= ready_done;
        end
    end

    sequence s_fourth_return;
        i_clk_en && synth_autocal_select == rfcal_pkg::RFCAL_CAL_FOURTH_RETURN && auto_return;
    endsequence

    sequence s_quiet_cycle;
        !o_synth_cal_start;
    endsequence

    a_ready_pair: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        o_chip_ready_n != o_osc_settled_flag)
        else $error("ready and settled flag disagree");

    a_never_autocal: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_clk_en && synth_autocal_select == rfcal_pkg::RFCAL_CAL_NEVER && !i_calibrate_strobe)
        |=> s_quiet_cycle)
        else $error("calibration without strobe in never mode");

    a_rx_entry_cal: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_clk_en && synth_autocal_select == rfcal_pkg::RFCAL_CAL_RX_ENTRY && i_idle_to_rx)
        |=> o_synth_cal_start)
        else $error("missed calibration on receive entry");

    a_each_return: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_clk_en && synth_autocal_select == rfcal_pkg::RFCAL_CAL_EACH_RETURN && auto_return)
        |=> o_synth_cal_start && o_auto_return_idle)
        else $error("missed calibration on automatic return");

    a_fourth_skip: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (s_fourth_return and (!quad_wrap && !i_calibrate_strobe && !i_idle_to_rx))
        |=> s_quiet_cycle)
        else $error("calibration on a skipped return");

    a_fourth_fire: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (s_fourth_return and quad_wrap) |=> o_synth_cal_start && quad_r == 2'h0)
        else $error("no calibration on counter wrap");

    a_sleep_keep: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_clk_en && i_sleep) |=> (o_crystal_osc_en == $past(keep_osc_in_sleep)))
        else $error("oscillator enable wrong in sleep");

    a_stay_rx: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_clk_en && i_after_receive_state_select == `RFCAL_RXOFF_STAY)
        |=> !o_auto_return_idle && $stable(quad_r))
        else $error("return to idle while staying in receive");

    // Oscillator off, then one enabled edge for the ready flop
    sequence s_osc_drop;
        i_clk_en && !o_crystal_osc_en ##1 i_clk_en;
    endsequence

    a_reg_write: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_clk_en && i_reg_wr && reg_hit)
        |=> cfg_r == ($past(i_reg_wdata) & `RFCAL_USED_MASK))
        else $error("register write not stored");

    a_reg_hold: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        !(i_clk_en && i_reg_wr && reg_hit) |=> $stable(cfg_r))
        else $error("register changed without a write");

    a_read_data: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_clk_en && i_reg_rd && reg_hit) |=> o_reg_rdata == $past(cfg_r))
        else $error("read data differs from register");

    a_read_idle: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_clk_en && !(i_reg_rd && reg_hit)) |=> o_reg_rdata == 8'h00)
        else $error("read data not cleared");

    a_freeze_state: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        !i_clk_en |=> $stable(cfg_r) && $stable(quad_r) && $stable(o_reg_rdata)
            && $stable(o_synth_cal_start) && $stable(o_auto_return_idle)
            && $stable(o_crystal_osc_en) && $stable(o_chip_ready_n))
        else $error("state moved while clock enable low");

    a_quad_hold: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        !(i_clk_en && auto_return) |=> $stable(quad_r))
        else $error("return counter moved without a return");

    a_quad_step: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_clk_en && auto_return) |=> quad_r == $past(quad_r) + 2'h1)
        else $error("return counter did not advance");

    a_awake_osc: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_clk_en && !i_sleep) |=> o_crystal_osc_en)
        else $error("oscillator off while awake");

    a_strobe_cal: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_clk_en && i_calibrate_strobe) |=> o_synth_cal_start)
        else $error("host strobe did not calibrate");

    a_entry_only: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_clk_en && synth_autocal_select == rfcal_pkg::RFCAL_CAL_RX_ENTRY
            && !i_calibrate_strobe && !i_idle_to_rx) |=> s_quiet_cycle)
        else $error("calibration without receive entry");

    a_each_only: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_clk_en && synth_autocal_select == rfcal_pkg::RFCAL_CAL_EACH_RETURN
            && !i_calibrate_strobe && !auto_return) |=> s_quiet_cycle)
        else $error("calibration without automatic return");

    a_ready_hold: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_clk_en && !ready_done) |=> o_chip_ready_n && !o_osc_settled_flag)
        else $error("ready before timeout expired");

    a_ready_rearm: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        s_osc_drop |=> o_chip_ready_n)
        else $error("ready kept with oscillator off");

    a_return_follow: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_clk_en && auto_return) |=> o_auto_return_idle)
        else $error("automatic return not reported");

    a_return_quiet: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_clk_en && !auto_return) |=> !o_auto_return_idle)
        else $error("return reported without packet end");
endmodule : rfcal_top
